//--- src/spi_sync_pkg.sv
// constants for the slave-select synchronised serial port
package spi_sync_pkg;
	localparam logic [11:0] OFFSET_DATA_BUFFER = 12'h000;
	localparam logic [11:0] OFFSET_CONTROL_ONE = 12'h004;
	localparam logic [11:0] OFFSET_CONTROL_THREE = 12'h008;
	localparam logic [11:0] OFFSET_STATUS = 12'h00c;
	localparam logic [11:0] OFFSET_IRQ_STATUS = 12'h010;
	localparam logic [11:0] OFFSET_IRQ_MASK = 12'h014;
	localparam logic [11:0] OFFSET_POWER = 12'h018;
	// control one fields
	localparam int BIT_COLLISION = 7;
	localparam int BIT_OVERFLOW = 6;
	localparam int BIT_ENABLE = 5;
	localparam int BIT_IDLE_POLARITY = 4;
	localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
	localparam logic [3:0] MODE_SLAVE_NO_SELECT = 4'h5;
	// status fields
	localparam int BIT_SAMPLE_PHASE = 7;
	localparam int BIT_CLOCK_EDGE = 6;
	localparam int BIT_BUFFER_FULL = 0;
	// control three field
	localparam int BIT_BUFFER_OVERWRITE = 4;
	// interrupt status fields
	localparam int IRQ_BYTE_DONE = 0;
	localparam int IRQ_COLLISION = 1;
	localparam int IRQ_OVERFLOW = 2;
	localparam logic [2:0] IRQ_ALL = 3'h7;
	// reset value and last bit count of a byte
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] BITS_PER_BYTE_LAST = 3'h7;
endpackage

//--- src/spi_sync_slave.sv
// slave-select synchronised spi slave with apb register access
// Summary of operation
// - slave-select mode only when port mode field equals 0100 in slave mode
// - slave-select low enables shifting both ways and drives serial output
// - slave-select high releases serial output at once, even mid-byte; the code releases it on the third CLOCK edge after select rises
// - slave-select high or port enable cleared forces bit counter to zero
// - failed transfer returns to start state when slave-select goes high
// - in master mode sleep freezes the transfer, it resumes on wake; master mode is not built here
// - slave shifting follows the external clock in sleep, byte sets flag
// - unmasked byte completion raises wake during sleep, masked gives none
// - eighth bit copies shift register to buffer unless it overflows, sets full flag and irq
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module spi_sync_slave (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SERIAL_CLOCK_PIN,
	input  wire logic        SLAVE_SELECT_N,
	input  wire logic        SERIAL_IN_PIN,
	output logic             SERIAL_OUT_PIN,
	output logic             SERIAL_OUT_OE,
	output logic             IRQ,
	output logic             WAKE
);
	// synchronisers: first stage feeds only the second
	logic [1:0] sck_sync;
	logic [1:0] ss_sync;
	logic [1:0] sdi_sync;
	logic       sck_last;

	logic [7:0] data_buffer;
	logic [7:0] control_one;
	logic [7:0] control_three;
	logic [1:0] status_high;
	logic       buffer_full;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic       sleep;
	logic [7:0] shift;
	logic [2:0] bit_count;
	logic       tx_pending;

	typedef enum logic [1:0] {IDLE, SHIFTING} phase_type;
	phase_type phase;

	wire       sck = sck_sync[1];
	wire       ss_n = ss_sync[1];
	wire       sdi = sdi_sync[1];
	wire       enable = control_one[spi_sync_pkg::BIT_ENABLE];
	wire [3:0] mode = control_one[3:0];
	wire       ss_mode = enable && (mode == spi_sync_pkg::MODE_SLAVE_SELECT);
	wire       free_mode = enable && (mode == spi_sync_pkg::MODE_SLAVE_NO_SELECT);
	// the slave keeps shifting in sleep; sleep gates only the wake line, the registers stay usable
	wire       active = free_mode || (ss_mode && !ss_n);
	// clearing enable, or raising slave-select in mode 0100, puts the counter back to zero
	wire       logic_reset = !enable || (ss_mode && ss_n);
	// idle level of the clock and edge selection pick sample and launch edges
	wire       idle_pol = control_one[spi_sync_pkg::BIT_IDLE_POLARITY];
	wire       edge_sel = status_high[spi_sync_pkg::BIT_CLOCK_EDGE - 6];
	wire       sck_rise = sck && !sck_last;
	wire       sck_fall = !sck && sck_last;
	wire       lead_edge = idle_pol ? sck_fall : sck_rise;
	wire       trail_edge = idle_pol ? sck_rise : sck_fall;
	wire       sample_edge = edge_sel ? lead_edge : trail_edge;
	wire       launch_edge = edge_sel ? trail_edge : lead_edge;
	wire       sample = active && sample_edge;
	wire       byte_done = sample && (bit_count == spi_sync_pkg::BITS_PER_BYTE_LAST);
	wire [7:0] shifted = {shift[6:0], sdi};

	// apb decode
	wire       access = PSEL && PENABLE;
	wire       wr = access && PWRITE;
	wire       rd = access && !PWRITE;
	wire       hit_buf = (PADDR == spi_sync_pkg::OFFSET_DATA_BUFFER);
	wire       hit_c1 = (PADDR == spi_sync_pkg::OFFSET_CONTROL_ONE);
	wire       hit_c3 = (PADDR == spi_sync_pkg::OFFSET_CONTROL_THREE);
	wire       hit_st = (PADDR == spi_sync_pkg::OFFSET_STATUS);
	wire       hit_is = (PADDR == spi_sync_pkg::OFFSET_IRQ_STATUS);
	wire       hit_im = (PADDR == spi_sync_pkg::OFFSET_IRQ_MASK);
	wire       hit_pw = (PADDR == spi_sync_pkg::OFFSET_POWER);
	wire       mapped = hit_buf || hit_c1 || hit_c3 || hit_st || hit_is || hit_im || hit_pw;
	wire       busy = active && (phase == SHIFTING);
	wire       overwrite_ok = control_three[spi_sync_pkg::BIT_BUFFER_OVERWRITE];
	wire       buf_write = wr && hit_buf;
	// a write while a byte is moving is dropped and flagged as a collision
	wire       collide = buf_write && busy;
	wire       buf_load = buf_write && !busy;
	wire       overflow = byte_done && buffer_full && !overwrite_ok;
	wire [2:0] events = {overflow, collide, byte_done};
	wire [2:0] irq_clear = (wr && hit_is) ? PWDATA[2:0] : 3'h0;
	wire [2:0] next_irq_status = (irq_status & ~irq_clear) | events;
	wire       next_irq = |(next_irq_status & irq_mask);

	logic [7:0] read_byte;
	always_comb begin
		read_byte = 8'h00;
		if (hit_buf)
			read_byte = data_buffer;
		else if (hit_c1)
			read_byte = control_one;
		else if (hit_c3)
			read_byte = control_three;
		else if (hit_st)
			read_byte = {status_high, 5'h00, buffer_full};
		else if (hit_is)
			read_byte = {5'h00, irq_status};
		else if (hit_im)
			read_byte = {5'h00, irq_mask};
		else if (hit_pw)
			read_byte = {7'h00, sleep};
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sck_sync <= 2'h0;
			ss_sync <= 2'h3;
			sdi_sync <= 2'h0;
			sck_last <= 1'b0;
		end else begin
			sck_sync <= {sck_sync[0], SERIAL_CLOCK_PIN};
			ss_sync <= {ss_sync[0], SLAVE_SELECT_N};
			sdi_sync <= {sdi_sync[0], SERIAL_IN_PIN};
			sck_last <= sck;
		end
	end

	// apb slave: one wait-free access phase, unmapped addresses answer an error
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped;
			PRDATA <= (PSEL && !PENABLE && !PWRITE) ? {24'h000000, read_byte} : 32'h00000000;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			control_one <= spi_sync_pkg::RESET_BYTE;
			control_three <= spi_sync_pkg::RESET_BYTE;
			status_high <= 2'h0;
			irq_mask <= 3'h0;
			sleep <= 1'b0;
		end else begin
			if (wr && hit_c3)
				control_three <= PWDATA[7:0];
			if (wr && hit_st)
				status_high <= PWDATA[7:6];
			if (wr && hit_im)
				irq_mask <= PWDATA[2:0] & spi_sync_pkg::IRQ_ALL;
			// any unmasked event ends sleep, as the wake line does
			if (wr && hit_pw)
				sleep <= PWDATA[0];
			else if (next_irq)
				sleep <= 1'b0;
			// a flag event in the same cycle as a software write keeps its flag set
			if (wr && hit_c1)
				control_one <= PWDATA[7:0];
			if (collide)
				control_one[spi_sync_pkg::BIT_COLLISION] <= 1'b1;
			if (overflow)
				control_one[spi_sync_pkg::BIT_OVERFLOW] <= 1'b1;
		end
	end

	// set wins over a clear written in the same cycle
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			irq_status <= 3'h0;
			IRQ <= 1'b0;
			WAKE <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			IRQ <= next_irq;
			WAKE <= sleep && next_irq;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			data_buffer <= spi_sync_pkg::RESET_BYTE;
			buffer_full <= 1'b0;
		end else begin
			if (byte_done && !overflow)
				data_buffer <= shifted;
			else if (buf_load)
				data_buffer <= PWDATA[7:0];
			if (byte_done)
				buffer_full <= 1'b1;
			else if (rd && hit_buf && PREADY)
				buffer_full <= 1'b0;
		end
	end

	// serial engine; master mode is not built, so sleep never stops it
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			shift <= spi_sync_pkg::RESET_BYTE;
			bit_count <= 3'h0;
			phase <= IDLE;
			tx_pending <= 1'b0;
		end else if (buf_load) begin
			shift <= PWDATA[7:0];
			tx_pending <= 1'b1;
			bit_count <= 3'h0;
			phase <= IDLE;
		end else if (logic_reset) begin
			bit_count <= 3'h0;
			phase <= IDLE;
		end else if (sample) begin
			shift <= shifted;
			bit_count <= bit_count + 3'h1;
			phase <= byte_done ? IDLE : SHIFTING;
			if (byte_done)
				tx_pending <= 1'b0;
		end else if (active && launch_edge && phase == SHIFTING) begin
			phase <= SHIFTING;
		end
	end

	// output drives while selected, or unselected in mode 0101, and stops on the third CLOCK edge after select rises
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SERIAL_OUT_PIN <= 1'b0;
			SERIAL_OUT_OE <= 1'b0;
		end else begin
			SERIAL_OUT_OE <= active;
			SERIAL_OUT_PIN <= active ? shift[7] : 1'b0;
		end
	end
endmodule

//--- sim/spi_sync_checker.sv
// port assertions for the select-synchronised serial port
`timescale 1ns/1ns
module spi_sync_checker (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SLAVE_SELECT_N,
	input wire logic        SERIAL_OUT_PIN,
	input wire logic        SERIAL_OUT_OE,
	input wire logic        WAKE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// only judge release when select itself started the drive, mode 0101 drives unselected
	logic drv;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) drv <= 1'b0;
		else if ($rose(SERIAL_OUT_OE)) drv <= !SLAVE_SELECT_N;
	end
	a_ready_prompt: assert property (PSEL && PENABLE && !$past(PENABLE) |-> PREADY)
		else $error("ready missing in first access cycle");
	a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
	a_ready_access: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h00000000)
		else $error("read data outside answer");
	a_out_quiet: assert property (!SERIAL_OUT_OE |-> !SERIAL_OUT_PIN)
		else $error("serial out high while released");
	a_oe_release: assert property ($rose(SLAVE_SELECT_N) && drv |-> ##[1:5] !SERIAL_OUT_OE)
		else $error("serial out still driven after deselect");
	a_wake_pulse: assert property (WAKE |=> !WAKE)
		else $error("wake longer than one cycle");
	c_err: cover property (PSLVERR);
	c_wake: cover property (WAKE);
	c_release: cover property ($rose(SLAVE_SELECT_N) && drv);
endmodule
bind spi_sync_slave spi_sync_checker spi_sync_checker_i (.*);

//--- sim/spi_master_model.sv
// behavioural spi master: clock idles low, slave samples on the falling edge
`timescale 1ns/1ns
module spi_master_model (
	output logic      sclk,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b1;
	end
	// 800 ns clock period; data moves mid-low, away from the slave's sampling edge
	// miso is read just before the fall, once the slave has settled the bit
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		#37 ss_n = 1'b0;
		#200;
		for (int i = 0; i < n; i++) begin
			mosi = tx[7-i];
			#200 sclk = 1'b1;
			#390 rx[7-i] = miso;
			#10 sclk = 1'b0;
			#200;
		end
		#400 ss_n = 1'b1;
		mosi = ~mosi;
	endtask
endmodule

//--- sim/spi_slave_select_sync_sleep_test.sv
// self-checking bench for the select-synchronised serial port
`timescale 1ns/1ns
module spi_slave_select_sync_sleep_test;
	logic        CLOCK, RST, PSEL, PENABLE, PWRITE, err;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, q;
	logic        PREADY, PSLVERR, sclk, ss_n, mosi, miso, oe, IRQ, WAKE;
	logic [7:0]  rx;
	int          bad_count, cmp_count, cyc, wakes;
	spi_sync_slave spi_sync_slave_i (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SERIAL_CLOCK_PIN(sclk),
		.SLAVE_SELECT_N(ss_n), .SERIAL_IN_PIN(mosi), .SERIAL_OUT_PIN(miso),
		.SERIAL_OUT_OE(oe), .IRQ(IRQ), .WAKE(WAKE));
	spi_master_model spi_master_model_i (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (WAKE === 1'b1) wakes++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h00000000);
		chk(q, exp, m);
	endtask
	// one received byte: flags, buffer, then clear for the next test
	task automatic got_byte(input logic [7:0] b, input logic i);
		repeat (8) @(posedge CLOCK);
		chk(IRQ, i, "irq");
		rd(spi_sync_pkg::OFFSET_STATUS, 32'h1, "full");
		rd(spi_sync_pkg::OFFSET_DATA_BUFFER, b, "buffer");
		rd(spi_sync_pkg::OFFSET_STATUS, 32'h0, "full clear");
		apb(1'b1, spi_sync_pkg::OFFSET_IRQ_STATUS, 32'h7);
		repeat (2) @(posedge CLOCK);
		chk(IRQ, 1'b0, "irq clear");
	endtask
	initial begin
		{RST, PSEL, PENABLE, PWRITE} = 4'h8;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		repeat (6) @(posedge CLOCK);
		RST <= 1'b0;
		rd(spi_sync_pkg::OFFSET_STATUS, 32'h0, "status reset");
		apb(1'b0, 12'h01c, 32'h0);
		chk(err, 1'b1, "unmapped");
		$display("test registers ended");
		apb(1'b1, spi_sync_pkg::OFFSET_STATUS, 32'h0);
		apb(1'b1, spi_sync_pkg::OFFSET_IRQ_MASK, 32'h1);
		apb(1'b1, spi_sync_pkg::OFFSET_CONTROL_ONE, 32'h20);
		spi_master_model_i.xfer(8'h99, 8, rx);
		repeat (8) @(posedge CLOCK);
		chk({oe, IRQ}, 2'b00, "idle mode");
		apb(1'b1, spi_sync_pkg::OFFSET_CONTROL_ONE, 32'h25);
		repeat (4) @(posedge CLOCK);
		chk(oe, 1'b1, "free mode drives unselected");
		$display("test wrong mode ended");
		apb(1'b1, spi_sync_pkg::OFFSET_CONTROL_ONE, 32'h24);
		apb(1'b1, spi_sync_pkg::OFFSET_DATA_BUFFER, 32'ha5);
		spi_master_model_i.xfer(8'h3c, 8, rx);
		chk(rx, 8'ha5, "serial out");
		got_byte(8'h3c, 1'b1);
		spi_master_model_i.xfer(8'hff, 3, rx);
		repeat (6) @(posedge CLOCK);
		chk(oe, 1'b0, "released");
		spi_master_model_i.xfer(8'h81, 8, rx);
		got_byte(8'h81, 1'b1);
		$display("test realign ended");
		fork
			spi_master_model_i.xfer(8'h5a, 8, rx);
			begin
				repeat (30) @(posedge CLOCK);
				apb(1'b1, spi_sync_pkg::OFFSET_DATA_BUFFER, 32'h77);
			end
		join
		rd(spi_sync_pkg::OFFSET_CONTROL_ONE, 32'ha4, "collision");
		got_byte(8'h5a, 1'b1);
		apb(1'b1, spi_sync_pkg::OFFSET_CONTROL_ONE, 32'h24);
		$display("test collision ended");
		apb(1'b1, spi_sync_pkg::OFFSET_POWER, 32'h1);
		spi_master_model_i.xfer(8'hc3, 8, rx);
		got_byte(8'hc3, 1'b1);
		chk(wakes, 1, "wake");
		apb(1'b1, spi_sync_pkg::OFFSET_IRQ_MASK, 32'h0);
		apb(1'b1, spi_sync_pkg::OFFSET_POWER, 32'h1);
		spi_master_model_i.xfer(8'h3e, 8, rx);
		got_byte(8'h3e, 1'b0);
		chk(wakes, 1, "no wake");
		$display("test sleep ended");
		tally_and_finish();
	end
endmodule
